// file: avm_consts.vh
// constants for the alpha video mixer datapath
`ifndef AVM_CONSTS_VH
`define AVM_CONSTS_VH
// host port addresses
`define AVM_PORT_RAM_WR_ADDR 3'h0
`define AVM_PORT_RAM_DATA 3'h1
`define AVM_PORT_RAM_RD_ADDR 3'h3
`define AVM_PORT_CTL_DATA 3'h5
`define AVM_PORT_MASK 3'h6
`define AVM_PORT_CTL_ADDR 3'h7
// control address register fields
`define AVM_RAM_SEL_HI 7
`define AVM_RAM_SEL_LO 6
`define AVM_RAM_SEL_ALPHA 2'h3
`define AVM_CTL_IDX_HI 3
`define AVM_CTL_IDX_LO 0
// control register indexes
`define AVM_REG_MIX 4'h0
`define AVM_REG_ROUTE 4'h1
`define AVM_REG_OUTFMT 4'h2
`define AVM_REG_FILL0 4'h3
`define AVM_REG_FILL1 4'h4
`define AVM_REG_FILL2 4'h5
`define AVM_REG_ALPHA 4'h6
`define AVM_REG_CONV 4'h7
`define AVM_REG_LAST 4'h8
// field positions
`define AVM_BIT_GAIN9 0
`define AVM_TFN_HI 2
`define AVM_TFN_LO 1
`define AVM_BIT_OUT_EN 3
`define AVM_SEL_HI 2
`define AVM_SEL_LO 0
`define AVM_BIT_EXT_SEL 3
`define AVM_BIT_PASS_MODE 4
`define AVM_BIT_PASS_SRC_B 5
`define AVM_OSRC_HI 7
`define AVM_OSRC_LO 6
`define AVM_BIT_FMT422 0
`define AVM_PSRC_HI 2
`define AVM_PSRC_LO 1
`define AVM_BIT_MATRIX 3
`define AVM_BIT_YCC_MODE 4
`define AVM_BIT_TABLE_EN 5
`define AVM_BIT_OFFSET_CONV 0
`define AVM_BIT_CONV_PD 1
`define AVM_BIT_PEDESTAL 2
`define AVM_BIT_OVL_PD 3
// reset values
`define AVM_RST_CTL 8'h00
`define AVM_RST_MASK 8'hff
// transfer functions
`define AVM_TFN_FOREGROUND 2'h1
`define AVM_TFN_BACKGROUND 2'h2
// crosspoint codes (v1 first)
`define AVM_XP_AB 3'h0
`define AVM_XP_BA 3'h1
`define AVM_XP_AF 3'h2
`define AVM_XP_FA 3'h3
`define AVM_XP_BF 3'h4
`define AVM_XP_FB 3'h5
// output and preview sources
`define AVM_SRC_MIX 2'h0
`define AVM_SRC_A 2'h1
`define AVM_SRC_B 2'h2
// gain and converter figures
`define AVM_UNITY 9'h100
`define AVM_ALPHA_FULL 8'hff
`define AVM_PEDESTAL_IU 9'h015
`define AVM_SYNC_IU 9'h06e
`define AVM_ZERO_CHROMA 9'h080
`define AVM_CHROMA_MID 10'h080
`define AVM_MAT_RV 10'h167
`define AVM_MAT_GU 10'h058
`define AVM_MAT_GV 10'h0b7
`define AVM_MAT_BU 10'h1c6
`endif

// file: avm_fifo.v
// small synchronous fifo with valid/ready on both sides
module avm_fifo #(
    parameter WIDTH = 25,
    parameter DEPTH = 4,
    parameter ADDR_W = 2
) (
    input wire sys_clk,
    input wire reset_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [ADDR_W:0] count
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [ADDR_W-1:0] wr_ptr;
    reg [ADDR_W-1:0] rd_ptr;
    reg [ADDR_W:0] fill;
    wire push;
    wire pop;
    localparam [ADDR_W:0] FULL = DEPTH[ADDR_W:0];
    localparam integer LAST_I = DEPTH - 1;
    localparam [ADDR_W-1:0] LAST = LAST_I[ADDR_W-1:0];

    assign in_ready = (fill != FULL);
    assign out_valid = (fill != {(ADDR_W+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign count = fill;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge sys_clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr <= {ADDR_W{1'b0}};
            rd_ptr <= {ADDR_W{1'b0}};
            fill <= {(ADDR_W+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == LAST) ? {ADDR_W{1'b0}} : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == LAST) ? {ADDR_W{1'b0}} : rd_ptr + 1'b1;
            if (push && !pop)
                fill <= fill + 1'b1;
            else if (pop && !push)
                fill <= fill - 1'b1;
        end
    end
endmodule // avm_fifo

// file: avm_mixer.v
// alpha video mixer datapath with host port, output formatter and preview codes
// Overview of operation
// - a nine-bit alpha is captured with every accepted pixel
// - gain-width bit: alpha 0ff gives 256/256 in 8-bit, 255/256 in 9-bit
// - alpha 000..0fe gives gain value/256, 100 gives full 256 steps
// - low alpha byte addresses a 256x8 remap table replacing incoming alpha
// - alpha bit 8 forces v1 gain 256/256 and, outside background mode, v2 gain 0/256
// - table enable low bypasses the table; host still reaches its contents
// - fill colour held in control registers 3, 4 and 5
// - crosspoint routes an ordered pair of a, b, fill to v1 and v2
// - crosspoint from register, or from external select pins when enabled
// - three independent component blenders, one per colour component
// - default mode output is alpha*v1 plus (1-alpha)*v2
// - foreground mode gives alpha*v1, background mode alpha*v1 plus v2
// - alpha, a and b paths have equal pipeline delay
// - pass mode sends data captured with pass window low through unaltered
// - output carries mixer result or crosspoint a or b input
// - formatter makes 16-bit 4:2:2 when enabled, else full 24-bit word
// - output registered on clock edge; enable bit low floats the port
// - preview fed from a, b or mix, optional colour matrix first
// - preview format bit turns two's complement chroma to offset binary
// - separate power-down bits for converters and overlay memory
// - green code adds pedestal and sync terms; blue and red skip sync
// - pedestal enable lives in control register 7 bit 2
// - luma/chroma converter mode with matrix off forces chroma codes to 128 when blanked
`include "avm_consts.vh"
module avm_mixer #(
    parameter FIFO_DEPTH = 4,
    parameter FIFO_ADDR_W = 2
) (
    input wire sys_clk,
    input wire reset_n,
    input wire [2:0] host_addr,
    input wire [7:0] host_data_in,
    output reg [7:0] host_data_out,
    output reg host_data_oe,
    input wire host_cs_n,
    input wire host_wr_n,
    input wire host_rd_n,
    input wire pixel_in_valid,
    output reg pixel_in_ready,
    input wire [8:0] alpha_in,
    input wire [23:0] primary_pixel_in,
    input wire [23:0] secondary_pixel_in,
    input wire [2:0] ext_source_select,
    input wire pass_window_n,
    input wire preview_blank_n,
    input wire preview_sync_n,
    output reg [23:0] mixed_pixel_out,
    output reg mixed_out_valid,
    input wire mixed_out_ready,
    output reg mixed_out_oe,
    output reg [8:0] conv_code_g,
    output reg [8:0] conv_code_b,
    output reg [8:0] conv_code_r,
    output reg converter_power_down,
    output reg overlay_ram_power_down
);
    // host port synchronisers
    reg [2:0] addr_s1, addr_s2;
    reg [7:0] data_s1, data_s2;
    reg cs_n_s1, cs_n_s2, wr_n_s1, wr_n_s2, wr_n_s3, rd_n_s1, rd_n_s2, rd_n_s3;
    reg [7:0] ctl [0:8];
    reg [7:0] ctl_addr;
    reg [7:0] mask_reg;
    reg [7:0] ram_wr_addr;
    reg [7:0] ram_rd_addr;
    reg [7:0] alpha_remap_table [0:255];
    integer i;

    wire wr_event = wr_n_s2 && !wr_n_s3 && !cs_n_s2;
    wire rd_event = rd_n_s2 && !rd_n_s3 && !cs_n_s2;
    wire [3:0] ctl_idx = ctl_addr[`AVM_CTL_IDX_HI:`AVM_CTL_IDX_LO];
    wire ram_is_alpha = (ctl_addr[`AVM_RAM_SEL_HI:`AVM_RAM_SEL_LO] == `AVM_RAM_SEL_ALPHA);
    wire [7:0] ram_wr_next = ram_wr_addr + 8'h01;

    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            addr_s1 <= 3'h0;
            addr_s2 <= 3'h0;
            data_s1 <= 8'h00;
            data_s2 <= 8'h00;
            cs_n_s1 <= 1'b1;
            cs_n_s2 <= 1'b1;
            wr_n_s1 <= 1'b1;
            wr_n_s2 <= 1'b1;
            wr_n_s3 <= 1'b1;
            rd_n_s1 <= 1'b1;
            rd_n_s2 <= 1'b1;
            rd_n_s3 <= 1'b1;
        end
        else
        begin
            addr_s1 <= host_addr;
            addr_s2 <= addr_s1;
            data_s1 <= host_data_in;
            data_s2 <= data_s1;
            cs_n_s1 <= host_cs_n;
            cs_n_s2 <= cs_n_s1;
            wr_n_s1 <= host_wr_n;
            wr_n_s2 <= wr_n_s1;
            wr_n_s3 <= wr_n_s2;
            rd_n_s1 <= host_rd_n;
            rd_n_s2 <= rd_n_s1;
            rd_n_s3 <= rd_n_s2;
        end
    end

    // table has no reset; contents are host-loaded
    always @(posedge sys_clk)
    begin
        if (wr_event && addr_s2 == `AVM_PORT_RAM_DATA && ram_is_alpha)
            alpha_remap_table[ram_wr_next] <= data_s2;
    end

    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (i = 0; i < 9; i = i + 1)
                ctl[i] <= `AVM_RST_CTL;
            ctl_addr <= 8'h00;
            mask_reg <= `AVM_RST_MASK;
            ram_wr_addr <= 8'h00;
            ram_rd_addr <= 8'h00;
        end
        else
        begin
            if (wr_event)
            begin
                case (addr_s2)
                    `AVM_PORT_RAM_WR_ADDR: ram_wr_addr <= data_s2;
                    `AVM_PORT_RAM_RD_ADDR: ram_rd_addr <= data_s2;
                    `AVM_PORT_CTL_ADDR: ctl_addr <= data_s2;
                    `AVM_PORT_MASK: mask_reg <= data_s2;
                    // pointer steps before the write lands
                    `AVM_PORT_RAM_DATA: if (ram_is_alpha) ram_wr_addr <= ram_wr_next;
                    // fill colour and other control registers
                    `AVM_PORT_CTL_DATA: if (ctl_idx <= `AVM_REG_LAST) ctl[ctl_idx] <= data_s2;
                    default: ;
                endcase
            end
            if (rd_event && addr_s2 == `AVM_PORT_RAM_DATA && ram_is_alpha)
                ram_rd_addr <= ram_rd_addr + 8'h01;
        end
    end

    reg [7:0] rd_mux;
    always @*
    begin
        case (addr_s2)
            `AVM_PORT_RAM_WR_ADDR: rd_mux = ram_wr_addr;
            `AVM_PORT_RAM_DATA: rd_mux = ram_is_alpha ? alpha_remap_table[ram_rd_addr] : 8'h00;
            `AVM_PORT_RAM_RD_ADDR: rd_mux = ram_rd_addr;
            `AVM_PORT_CTL_DATA: rd_mux = (ctl_idx <= `AVM_REG_LAST) ? ctl[ctl_idx] : 8'h00;
            `AVM_PORT_MASK: rd_mux = mask_reg;
            `AVM_PORT_CTL_ADDR: rd_mux = ctl_addr;
            default: rd_mux = 8'h00;
        endcase
    end

    // control fields
    wire gain9 = ctl[`AVM_REG_MIX][`AVM_BIT_GAIN9];
    wire [1:0] tfn = ctl[`AVM_REG_MIX][`AVM_TFN_HI:`AVM_TFN_LO];
    wire out_en_bit = ctl[`AVM_REG_MIX][`AVM_BIT_OUT_EN];
    wire ext_sel_en = ctl[`AVM_REG_ROUTE][`AVM_BIT_EXT_SEL];
    wire pass_mode = ctl[`AVM_REG_ROUTE][`AVM_BIT_PASS_MODE];
    wire pass_src_b = ctl[`AVM_REG_ROUTE][`AVM_BIT_PASS_SRC_B];
    wire [1:0] out_src = ctl[`AVM_REG_ROUTE][`AVM_OSRC_HI:`AVM_OSRC_LO];
    wire fmt422 = ctl[`AVM_REG_OUTFMT][`AVM_BIT_FMT422];
    wire [1:0] prev_src = ctl[`AVM_REG_OUTFMT][`AVM_PSRC_HI:`AVM_PSRC_LO];
    wire matrix_en = ctl[`AVM_REG_OUTFMT][`AVM_BIT_MATRIX];
    wire ycc_mode = ctl[`AVM_REG_OUTFMT][`AVM_BIT_YCC_MODE];
    wire table_en = ctl[`AVM_REG_ALPHA][`AVM_BIT_TABLE_EN];
    wire offset_conv = ctl[`AVM_REG_CONV][`AVM_BIT_OFFSET_CONV];
    wire pedestal = ctl[`AVM_REG_CONV][`AVM_BIT_PEDESTAL];
    wire [23:0] fill = {ctl[`AVM_REG_FILL0], ctl[`AVM_REG_FILL1], ctl[`AVM_REG_FILL2]};

    // stage 1: capture alpha and pixels together
    reg s1_v, s1_pass, s1_blank_n, s1_sync_n;
    reg [8:0] s1_alpha;
    reg [23:0] s1_a, s1_b;
    reg [2:0] s1_sel;
    wire accept = pixel_in_valid && pixel_in_ready;

    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s1_v <= 1'b0;
            s1_pass <= 1'b0;
            s1_blank_n <= 1'b0;
            s1_sync_n <= 1'b0;
            s1_alpha <= 9'h000;
            s1_a <= 24'h000000;
            s1_b <= 24'h000000;
            s1_sel <= `AVM_XP_AB;
        end
        else
        begin
            s1_v <= accept;
            s1_blank_n <= preview_blank_n;
            s1_sync_n <= preview_sync_n;
            if (accept)
            begin
                s1_alpha <= alpha_in;
                s1_a <= primary_pixel_in;
                s1_b <= secondary_pixel_in;
                s1_sel <= ext_sel_en ? ext_source_select : ctl[`AVM_REG_ROUTE][`AVM_SEL_HI:`AVM_SEL_LO];
                s1_pass <= pass_mode && !pass_window_n;
            end
        end
    end

    // stage 2: alpha remap, gain and crosspoint
    reg [7:0] alpha_lo;
    reg [8:0] gain;
    reg [23:0] xp_v1, xp_v2;
    always @*
    begin
        alpha_lo = table_en ? alpha_remap_table[s1_alpha[7:0]] : s1_alpha[7:0];
        if (s1_alpha[8])
            gain = `AVM_UNITY;
        // 8-bit gain makes full code unity
        else if (!gain9 && alpha_lo == `AVM_ALPHA_FULL)
            gain = `AVM_UNITY;
        else
            gain = {1'b0, alpha_lo};
        case (s1_sel)
            `AVM_XP_AB: begin xp_v1 = s1_a; xp_v2 = s1_b; end
            `AVM_XP_BA: begin xp_v1 = s1_b; xp_v2 = s1_a; end
            `AVM_XP_AF: begin xp_v1 = s1_a; xp_v2 = fill; end
            `AVM_XP_FA: begin xp_v1 = fill; xp_v2 = s1_a; end
            `AVM_XP_BF: begin xp_v1 = s1_b; xp_v2 = fill; end
            `AVM_XP_FB: begin xp_v1 = fill; xp_v2 = s1_b; end
            default: begin xp_v1 = s1_a; xp_v2 = s1_b; end
        endcase
    end

    reg s2_v, s2_pass, s2_blank_n, s2_sync_n;
    reg [8:0] s2_gain;
    reg [23:0] s2_v1, s2_v2, s2_a, s2_b;
    // every path passes the same two stages
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s2_v <= 1'b0;
            s2_pass <= 1'b0;
            s2_blank_n <= 1'b0;
            s2_sync_n <= 1'b0;
            s2_gain <= 9'h000;
            s2_v1 <= 24'h000000;
            s2_v2 <= 24'h000000;
            s2_a <= 24'h000000;
            s2_b <= 24'h000000;
        end
        else
        begin
            s2_v <= s1_v;
            s2_pass <= s1_pass;
            s2_blank_n <= s1_blank_n;
            s2_sync_n <= s1_sync_n;
            s2_gain <= gain;
            s2_v1 <= xp_v1;
            s2_v2 <= xp_v2;
            s2_a <= s1_a;
            s2_b <= s1_b;
        end
    end

    function [7:0] blend;
        input [8:0] g;
        input [7:0] v1;
        input [7:0] v2;
        input [1:0] tf;
        reg [16:0] p1;
        reg [16:0] p2;
        reg [16:0] sum;
        reg [8:0] bg;
        begin
            p1 = {8'h00, g} * {9'h000, v1};
            p2 = ({8'h00, `AVM_UNITY} - {8'h00, g}) * {9'h000, v2};
            sum = p1 + p2;
            bg = {1'b0, p1[15:8]} + {1'b0, v2};
            if (tf == `AVM_TFN_FOREGROUND)
                blend = p1[15:8];
            else if (tf == `AVM_TFN_BACKGROUND)
                blend = bg[8] ? 8'hff : bg[7:0];
            else
                blend = sum[15:8];
        end
    endfunction

    wire [23:0] mix_result = {blend(s2_gain, s2_v1[23:16], s2_v2[23:16], tfn),
                              blend(s2_gain, s2_v1[15:8], s2_v2[15:8], tfn),
                              blend(s2_gain, s2_v1[7:0], s2_v2[7:0], tfn)};

    reg [23:0] out_word;
    always @*
    begin
        if (s2_pass)
            out_word = pass_src_b ? s2_b : s2_a;
        else
        begin
            case (out_src)
                `AVM_SRC_A: out_word = s2_a;
                `AVM_SRC_B: out_word = s2_b;
                default: out_word = mix_result;
            endcase
        end
    end

    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [24:0] fifo_out_data;
    wire [FIFO_ADDR_W:0] fifo_count;
    wire pop = fifo_out_valid && (!mixed_out_valid || mixed_out_ready);

    avm_fifo #(
        .WIDTH(25),
        .DEPTH(FIFO_DEPTH),
        .ADDR_W(FIFO_ADDR_W)
    ) u_fifo (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .in_valid(s2_v),
        .in_ready(fifo_in_ready),
        .in_data({s2_pass, out_word}),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data),
        .count(fifo_count)
    );

    // credit check: words in flight plus stored never exceed depth
    wire [4:0] credit = {{(4 - FIFO_ADDR_W){1'b0}}, fifo_count} + {4'h0, s1_v} + {4'h0, s2_v}
                        + {4'h0, accept} + 5'h01;
    localparam [4:0] DEPTH_W = FIFO_DEPTH[4:0];

    reg chroma_phase;
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pixel_in_ready <= 1'b0;
            mixed_pixel_out <= 24'h000000;
            mixed_out_valid <= 1'b0;
            mixed_out_oe <= 1'b0;
            chroma_phase <= 1'b0;
            host_data_out <= 8'h00;
            host_data_oe <= 1'b0;
        end
        else
        begin
            pixel_in_ready <= (credit <= DEPTH_W) && fifo_in_ready;
            host_data_out <= rd_mux;
            host_data_oe <= !cs_n_s2 && !rd_n_s2;
            // port floats when enable bit low
            mixed_out_oe <= out_en_bit;
            if (pop)
            begin
                mixed_out_valid <= 1'b1;
                // 4:2:2 packs luma with alternating cb/cr
                if (fmt422 && !fifo_out_data[24])
                begin
                    mixed_pixel_out <= {8'h00, fifo_out_data[23:16],
                                        chroma_phase ? fifo_out_data[7:0] : fifo_out_data[15:8]};
                    chroma_phase <= !chroma_phase;
                end
                else
                begin
                    mixed_pixel_out <= fifo_out_data[23:0];
                    chroma_phase <= 1'b0;
                end
            end
            else if (mixed_out_ready)
                mixed_out_valid <= 1'b0;
        end
    end

    function [7:0] clamp8;
        input [11:0] v;
        begin
            clamp8 = v[11] ? 8'h00 : (v[10:8] != 3'h0) ? 8'hff : v[7:0];
        end
    endfunction

    // preview source, format conversion and optional matrix
    reg [23:0] pv_src, pv_fmt, pv_rgb;
    reg [11:0] y_x, cb_x, cr_x, t_r, t_g, t_b;
    reg [21:0] m_r, m_g, m_b;
    always @*
    begin
        case (prev_src)
            `AVM_SRC_A: pv_src = s2_a;
            `AVM_SRC_B: pv_src = s2_b;
            default: pv_src = mix_result;
        endcase
        // msb flip gives offset binary chroma
        pv_fmt = offset_conv ? (pv_src ^ 24'h008080) : pv_src;
        y_x = {4'h0, pv_fmt[23:16]};
        cb_x = {4'h0, pv_fmt[15:8]} - {2'b00, `AVM_CHROMA_MID};
        cr_x = {4'h0, pv_fmt[7:0]} - {2'b00, `AVM_CHROMA_MID};
        m_r = {{10{cr_x[11]}}, cr_x} * {12'h000, `AVM_MAT_RV};
        m_g = {{10{cb_x[11]}}, cb_x} * {12'h000, `AVM_MAT_GU} + {{10{cr_x[11]}}, cr_x} * {12'h000, `AVM_MAT_GV};
        m_b = {{10{cb_x[11]}}, cb_x} * {12'h000, `AVM_MAT_BU};
        t_r = y_x + m_r[19:8];
        t_g = y_x - m_g[19:8];
        t_b = y_x + m_b[19:8];
        // matrix output kept in g,b,r lane order
        pv_rgb = matrix_en ? {clamp8(t_g), clamp8(t_b), clamp8(t_r)} : pv_fmt;
    end

    wire [8:0] ped = pedestal ? `AVM_PEDESTAL_IU : 9'h000;
    wire [8:0] code_g = s2_blank_n ? ({1'b0, pv_rgb[23:16]} + ped) : 9'h000;
    wire [8:0] code_b = s2_blank_n ? ({1'b0, pv_rgb[15:8]} + ped) : 9'h000;
    wire [8:0] code_r = s2_blank_n ? ({1'b0, pv_rgb[7:0]} + ped) : 9'h000;
    wire chroma_blank = ycc_mode && !matrix_en && !s2_blank_n;

    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            conv_code_g <= 9'h000;
            conv_code_b <= 9'h000;
            conv_code_r <= 9'h000;
            converter_power_down <= 1'b0;
            overlay_ram_power_down <= 1'b0;
        end
        else
        begin
            converter_power_down <= ctl[`AVM_REG_CONV][`AVM_BIT_CONV_PD];
            overlay_ram_power_down <= ctl[`AVM_REG_CONV][`AVM_BIT_OVL_PD];
            if (ctl[`AVM_REG_CONV][`AVM_BIT_CONV_PD])
            begin
                conv_code_g <= 9'h000;
                conv_code_b <= 9'h000;
                conv_code_r <= 9'h000;
            end
            else
            begin
                conv_code_g <= code_g + (s2_sync_n ? `AVM_SYNC_IU : 9'h000);
                // blanked chroma sits at zero level
                conv_code_b <= chroma_blank ? `AVM_ZERO_CHROMA : code_b;
                conv_code_r <= chroma_blank ? `AVM_ZERO_CHROMA : code_r;
            end
        end
    end
endmodule // avm_mixer

// file: avm_mixer_chk.sv
// port assertions for the mixer datapath
module avm_mixer_chk #(
    parameter FIFO_DEPTH = 4
) (
    input wire sys_clk,
    input wire reset_n,
    input wire pixel_in_valid,
    input wire pixel_in_ready,
    input wire [23:0] mixed_pixel_out,
    input wire mixed_out_valid,
    input wire mixed_out_ready,
    input wire [8:0] conv_code_g,
    input wire preview_blank_n,
    input wire preview_sync_n,
    input wire converter_power_down
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    sequence take;
        pixel_in_valid && pixel_in_ready;
    endsequence
    wire up = pixel_in_valid && pixel_in_ready;
    wire dn = mixed_out_valid && mixed_out_ready;
    reg [3:0] held;
    // words taken but not yet drained
    always @(posedge sys_clk or negedge reset_n)
        if (!reset_n)
            held <= 4'h0;
        else
            held <= held + {3'h0, up} - {3'h0, dn};
    a_stall_hold: assert property (mixed_out_valid && !mixed_out_ready
        |=> mixed_out_valid && $stable(mixed_pixel_out)) else $error("stall hold");
    a_take_drain: assert property (take |-> ##[3:40] dn) else $error("lost word");
    a_fifo_bound: assert property (held <= FIFO_DEPTH + 1) else $error("overfill");
    a_valid_cause: assert property (mixed_out_valid |-> held != 4'h0) else $error("stray word");
    a_idle_ready: assert property (held == 4'h0 |-> ##[0:2] pixel_in_ready) else $error("ready stuck");
    a_last_drain: assert property (dn && held == 4'h1 |=> !mixed_out_valid) else $error("extra word");
    a_pd_zero: assert property (converter_power_down && $past(converter_power_down)
        |-> conv_code_g == 9'h000) else $error("code in power down");
    a_blank_green: assert property (!$past(preview_blank_n, 3) && !$past(converter_power_down, 3)
        && !converter_power_down |-> conv_code_g == ($past(preview_sync_n, 3) ? 9'h06e : 9'h000))
        else $error("blank green");
endmodule // avm_mixer_chk
bind avm_mixer avm_mixer_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
    .pixel_in_valid(pixel_in_valid), .pixel_in_ready(pixel_in_ready), .mixed_pixel_out(mixed_pixel_out),
    .mixed_out_valid(mixed_out_valid), .mixed_out_ready(mixed_out_ready), .conv_code_g(conv_code_g),
    .preview_blank_n(preview_blank_n), .preview_sync_n(preview_sync_n), .converter_power_down(converter_power_down));

// file: avm_sink.sv
// downstream sink that can stall
module avm_sink (
    input wire logic clk,
    input wire logic stall,
    output wire logic ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph = 2'h0;
    // one ready in four while stalling
    always @(posedge clk)
        ph <= ph + 2'h1;
    assign ready = !stall || ph == 2'h3;
endmodule // avm_sink

// file: tb_top.sv
// self-checking bench for the mixer datapath
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, cs_n, wr_n, rd_n, pv, blk_n, syn_n, pw_n, stall;
    logic [2:0] ha, xs;
    logic [7:0] hd;
    logic [8:0] al;
    logic [23:0] pa, pb;
    wire [7:0] hq;
    wire [23:0] mo;
    wire [8:0] cg, cb, cr;
    wire hoe, rdy, mv, mr, moe, cpd, opd;
    int mismatches, tests_run;
    logic [32:0] rows [6] = '{{9'h000, 24'heeffdd}, {9'h040, 24'he1f2d0}, {9'h080, 24'hd4e5c3},
        {9'h0ff, 24'hbbccaa}, {9'h100, 24'hbbccaa}, {9'h1ff, 24'hbbccaa}};
    avm_mixer dut (.sys_clk(clk), .reset_n(rst_n), .host_addr(ha), .host_data_in(hd), .host_data_out(hq),
        .host_data_oe(hoe), .host_cs_n(cs_n), .host_wr_n(wr_n), .host_rd_n(rd_n), .pixel_in_valid(pv),
        .pixel_in_ready(rdy), .alpha_in(al), .primary_pixel_in(pa), .secondary_pixel_in(pb),
        .ext_source_select(xs), .pass_window_n(pw_n), .preview_blank_n(blk_n), .preview_sync_n(syn_n),
        .mixed_pixel_out(mo), .mixed_out_valid(mv), .mixed_out_ready(mr), .mixed_out_oe(moe), .conv_code_g(cg),
        .conv_code_b(cb), .conv_code_r(cr), .converter_power_down(cpd), .overlay_ram_power_down(opd));
    avm_sink u_sink (.clk(clk), .stall(stall), .ready(mr));
    initial
    begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    task chk(string n, logic [23:0] e, logic [23:0] s);
        tests_run++;
        if (s !== e)
        begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task hw(logic [2:0] a, logic [7:0] d);
        @(posedge clk);
        {ha, hd, cs_n, wr_n} <= {a, d, 2'b00};
        repeat (4) @(posedge clk);
        wr_n <= 1;
        repeat (4) @(posedge clk);
        cs_n <= 1;
        repeat (4) @(posedge clk);
    endtask
    // read data and drive enable stand from the third edge on
    task rd(logic [2:0] a, logic [7:0] e);
        @(posedge clk);
        {ha, cs_n, rd_n} <= {a, 2'b00};
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("rd", {15'h0, 1'b1, e}, {15'h0, hoe, hq});
        @(posedge clk);
        rd_n <= 1;
        repeat (4) @(posedge clk);
        cs_n <= 1;
        repeat (4) @(posedge clk);
    endtask
    task cw(logic [3:0] i, logic [7:0] d);
        hw(3'h7, {4'h0, i});
        hw(3'h5, d);
    endtask
    task px(logic [8:0] a, logic [23:0] p, logic [23:0] q, logic [23:0] e);
        @(posedge clk);
        {al, pa, pb, pv} <= {a, p, q, 1'b1};
        do @(negedge clk); while (rdy !== 1'b1);
        @(posedge clk);
        pv <= 0;
        repeat (60)
        begin
            @(negedge clk);
            if ((mv && mr) === 1'b1)
                break;
        end
        chk("mix", e, mo);
        @(posedge clk);
    endtask
    task results;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #400us;
        mismatches++;
        results;
    end
    initial
    begin
        {rst_n, cs_n, wr_n, rd_n, pv, blk_n, syn_n, pw_n, stall} = 9'b011101110;
        {ha, xs, hd, al, pa, pb} = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1;
        repeat (2) @(posedge clk);
        cw(4'h0, 8'h08);
        stall <= 1;
        foreach (rows[i])
            px(rows[i][32:24], 24'hbbccaa, 24'heeffdd, rows[i][23:0]);
        stall <= 0;
        $display("rows done");
        cw(4'h0, 8'h09);
        px(9'h0ff, 24'hffffff, 24'h000000, 24'hfefefe);
        px(9'h1ff, 24'hffffff, 24'h000000, 24'hffffff);
        cw(4'h0, 8'h0a);
        px(9'h080, 24'hffffff, 24'h123456, 24'h7f7f7f);
        cw(4'h0, 8'h0c);
        px(9'h080, 24'h808080, 24'h101010, 24'h505050);
        $display("gain done");
        cw(4'h0, 8'h08);
        cw(4'h3, 8'h12);
        cw(4'h4, 8'h34);
        cw(4'h5, 8'h56);
        cw(4'h1, 8'h02);
        px(9'h000, 24'haaaaaa, 24'hbbbbbb, 24'h123456);
        cw(4'h1, 8'h08);
        xs <= 3'h1;
        px(9'h100, 24'h111111, 24'h222222, 24'h222222);
        cw(4'h6, 8'h20);
        hw(3'h7, 8'hc0);
        hw(3'h0, 8'h3f);
        hw(3'h1, 8'h80);
        px(9'h040, 24'h000000, 24'hffffff, 24'h7f7f7f);
        cw(4'h6, 8'h00);
        px(9'h040, 24'h000000, 24'hffffff, 24'h3f3f3f);
        hw(3'h7, 8'hc0);
        hw(3'h3, 8'h40);
        rd(3'h1, 8'h80);
        cw(4'h1, 8'h10);
        pw_n <= 0;
        px(9'h080, 24'h5a5a5a, 24'h000000, 24'h5a5a5a);
        pw_n <= 1;
        cw(4'h1, 8'h40);
        px(9'h080, 24'h13579b, 24'h000000, 24'h13579b);
        cw(4'h2, 8'h01);
        px(9'h080, 24'h112233, 24'h000000, 24'h001122);
        px(9'h080, 24'h445566, 24'h000000, 24'h004466);
        chk("oe", 24'h1, {23'h0, moe});
        cw(4'h0, 8'h00);
        chk("oe", 24'h0, {23'h0, moe});
        $display("route done");
        cw(4'h2, 8'h12);
        cw(4'h7, 8'h04);
        @(negedge clk);
        chk("ped", 24'h0000c7, {15'h0, cg});
        chk("bluered", {6'h0, 9'h06a, 9'h07b}, {6'h0, cb, cr});
        @(posedge clk);
        blk_n <= 0;
        repeat (5) @(negedge clk);
        chk("chroma", {6'h0, 9'h080, 9'h080}, {6'h0, cb, cr});
        @(posedge clk);
        syn_n <= 0;
        repeat (5) @(negedge clk);
        chk("green", 24'h0, {15'h0, cg});
        @(posedge clk);
        {blk_n, syn_n} <= 2'b11;
        cw(4'h7, 8'h0a);
        chk("pd", 24'h3, {22'h0, cpd, opd});
        $display("preview done");
        rst_n <= 0;
        repeat (2) @(negedge clk);
        chk("rst", 24'h0, {19'h0, mv, moe, hoe, cpd, opd});
        @(posedge clk);
        rst_n <= 1;
        rd(3'h6, 8'hff);
        rd(3'h7, 8'h00);
        $display("reset done");
        results;
    end
endmodule // tb_top
